/* File: design/selftest_map.svh */
// register offsets, field positions, reset values and counts for the self-test block
// assumes a classic wishbone slave with word-aligned 32-bit registers
`ifndef SELFTEST_MAP_SVH
`define SELFTEST_MAP_SVH

// ----------------------------------------
// register indexes and byte addresses
// ----------------------------------------
`define BYTE_TOTAL_IDX      8'h71
`define STATUS_CMD_IDX      8'h72
`define PKT_LEN_IDX         8'h7b
`define CONTROL_IDX         8'h16
`define IRQ_STATUS_IDX      8'h80
`define IRQ_MASK_IDX        8'h81
`define IDX_TO_ADDR(i)      {i, 2'b00}

// ----------------------------------------
// field positions
// ----------------------------------------
`define CMD_LOCK_BIT        0
`define CMD_CLEAR_BIT       1
`define BYTE_OVF_BIT        9
`define PKT_OVF_BIT         10
`define CTRL_SAT_BIT        0
`define CTRL_GEN_EN_BIT     1
`define IRQ_BYTE_OVF_BIT    0
`define IRQ_PKT_OVF_BIT     1
`define IRQ_PKT_DONE_BIT    2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define PKT_LEN_RESET       16'h05dc
`define CONTROL_RESET       16'h0000
`define PREAMBLE_NIBBLES    5'h0d
`define PREAMBLE_NIBBLE     4'h5
`define SFD_BYTE            8'hd5
`define IRQ_BITS            3

`endif

/* File: design/selftest_pkg.sv */
// types shared by the self-test block
// assumes nothing of its surroundings
package selftest_pkg;
  typedef enum logic [3:0] {
    GEN_IDLE     = 4'b0001,
    GEN_PREAMBLE = 4'b0010,
    GEN_SFD      = 4'b0100,
    GEN_PAYLOAD  = 4'b1000
  } gen_state_t;
endpackage : selftest_pkg

/* File: design/selftest_generator.sv */
// pseudo-random packet generator: nibble preamble, delimiter, random payload
// assumes a byte enable from the link side gates every output byte
`timescale 1ns/1ps
`default_nettype none
`include "selftest_map.svh"
module selftest_generator (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        enable_i,
  input  wire logic        byte_en_i,
  input  wire logic [15:0] generated_packet_length_i,
  output logic       [7:0] tx_data_o,
  output logic             tx_valid_o,
  output logic             tx_sfd_o,
  output logic             pkt_done_o
);
  selftest_pkg::gen_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [14:0] lfsr_reg, lfsr_next;
  logic [7:0]  data_reg, data_next;
  logic        valid_reg, valid_next, sfd_reg, sfd_next, done_reg, done_next;

  // ----------------------------------------
  // prbs step
  // ----------------------------------------
  function automatic logic [14:0] lfsr_step(input logic [14:0] s);
    lfsr_step = {s[13:0], s[14] ^ s[13]};
  endfunction : lfsr_step

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    lfsr_next  = lfsr_reg;
    data_next  = data_reg;
    valid_next = 1'b0;
    sfd_next   = 1'b0;
    done_next  = 1'b0;
    if (byte_en_i) begin
      unique case (state_reg)
        selftest_pkg::GEN_IDLE: begin
          if (enable_i && generated_packet_length_i != 16'h0000) begin
            state_next = selftest_pkg::GEN_PREAMBLE;
            cnt_next   = 16'h0000;
          end
        end
        selftest_pkg::GEN_PREAMBLE: begin
          // two nibbles per byte slot; the odd thirteenth is alone in the low half
          valid_next = 1'b1;
          data_next  = {`PREAMBLE_NIBBLE, `PREAMBLE_NIBBLE};
          if (cnt_reg + 16'h0002 >= {11'h000, `PREAMBLE_NIBBLES}) begin
            if (cnt_reg + 16'h0001 == {11'h000, `PREAMBLE_NIBBLES}) begin
              data_next = {4'h0, `PREAMBLE_NIBBLE};
            end
            state_next = selftest_pkg::GEN_SFD;
          end
          cnt_next = cnt_reg + 16'h0002;
        end
        selftest_pkg::GEN_SFD: begin
          valid_next = 1'b1;
          sfd_next   = 1'b1;
          data_next  = `SFD_BYTE;
          cnt_next   = 16'h0000;
          state_next = selftest_pkg::GEN_PAYLOAD;
        end
        selftest_pkg::GEN_PAYLOAD: begin
          valid_next = 1'b1;
          data_next  = lfsr_reg[7:0];
          lfsr_next  = lfsr_step(lfsr_step(lfsr_step(lfsr_step(
                         lfsr_step(lfsr_step(lfsr_step(lfsr_step(lfsr_reg))))))));
          cnt_next   = cnt_reg + 16'h0001;
          if (cnt_reg + 16'h0001 >= generated_packet_length_i) begin
            state_next = selftest_pkg::GEN_IDLE;
            done_next  = 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= selftest_pkg::GEN_IDLE;
      cnt_reg   <= 16'h0000;
      lfsr_reg  <= 15'h7fff;
      data_reg  <= 8'h00;
      valid_reg <= 1'b0;
      sfd_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      lfsr_reg  <= lfsr_next;
      data_reg  <= data_next;
      valid_reg <= valid_next;
      sfd_reg   <= sfd_next;
      done_reg  <= done_next;
    end
  end

  assign tx_data_o  = data_reg;
  assign tx_valid_o = valid_reg;
  assign tx_sfd_o   = sfd_reg;
  assign pkt_done_o = done_reg;
endmodule : selftest_generator
`default_nettype wire

/* File: design/prbs_selftest_counters.sv */
// self-test counters with wishbone slave, lock snapshots and overflow interrupts
// assumes checker byte and error strobes are same-clock one-cycle pulses
// Behaviour
// - sixteen-bit read-only received byte tally
// - byte tally saturates when saturate mode zero
// - byte tally frozen on lock writes
// - bit 0 write locks counters, no clear
// - bit 1 write locks and clears counters
// - packet overflow flag bit 10, sticky
// - byte overflow flag bit 9, sticky
// - eight-bit error tally, locked likewise
// - error tally saturates when saturate mode zero
// - packet size equals length field, resets 1500
// - thirteen 0x5 nibbles then 0xd5 delimiter
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "selftest_map.svh"
module prbs_selftest_counters (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_byte_i,
  input  wire logic        rx_err_i,
  input  wire logic        rx_pkt_i,
  input  wire logic        byte_en_i,
  output logic       [7:0] tx_data_o,
  output logic             tx_valid_o,
  output logic             tx_sfd_o,
  output logic             irq_o
);
  logic [15:0] byte_live_reg, byte_live_next, byte_snap_reg, byte_snap_next;
  logic [7:0]  err_live_reg, err_live_next, err_snap_reg, err_snap_next;
  logic [15:0] pkt_live_reg, pkt_live_next;
  logic        byte_ovf_reg, byte_ovf_next, pkt_ovf_reg, pkt_ovf_next;
  logic [15:0] pkt_len_reg, pkt_len_next, ctrl_reg, ctrl_next;
  logic [2:0]  irq_sts_reg, irq_sts_next, irq_msk_reg, irq_msk_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic        req, wr, lo_en, lock, clear, sat, pkt_done;
  logic [15:0] wdata;
  logic [7:0]  idx;
  logic [2:0]  events;

  // ----------------------------------------
  // counter step: wrap or stop at all ones
  // ----------------------------------------
  function automatic logic [16:0] bump16(input logic [15:0] v, input logic s);
    if (v == 16'hffff) begin
      bump16 = s ? {1'b1, 16'h0000} : {1'b0, 16'hffff};
    end else begin
      bump16 = {1'b0, v + 16'h0001};
    end
  endfunction : bump16

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign req   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr    = req && wb_we_i;
  assign lo_en = wb_sel_i[0] || wb_sel_i[1];
  assign idx   = wb_adr_i[9:2];
  assign wdata = wb_dat_i[15:0];
  assign sat   = ctrl_reg[`CTRL_SAT_BIT];
  assign lock  = wr && lo_en && idx == `STATUS_CMD_IDX
                 && (wdata[`CMD_LOCK_BIT] || wdata[`CMD_CLEAR_BIT]);
  assign clear = wr && lo_en && idx == `STATUS_CMD_IDX && wdata[`CMD_CLEAR_BIT];

  selftest_generator u_gen (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .enable_i                  (ctrl_reg[`CTRL_GEN_EN_BIT]),
    .byte_en_i                 (byte_en_i),
    .generated_packet_length_i (pkt_len_reg),
    .tx_data_o                 (tx_data_o),
    .tx_valid_o                (tx_valid_o),
    .tx_sfd_o                  (tx_sfd_o),
    .pkt_done_o                (pkt_done)
  );

  // ----------------------------------------
  // counters, snapshots, overflow flags
  // ----------------------------------------
  always_comb begin
    logic [16:0] b, p;
    logic [8:0]  e;
    b = bump16(byte_live_reg, sat);
    p = bump16(pkt_live_reg, sat);
    e = (err_live_reg == 8'hff) ? {1'b1, (sat ? 8'h00 : 8'hff)}
                                : {1'b0, err_live_reg + 8'h01};
    byte_live_next = rx_byte_i ? b[15:0] : byte_live_reg;
    err_live_next  = rx_err_i ? e[7:0] : err_live_reg;
    pkt_live_next  = rx_pkt_i ? p[15:0] : pkt_live_reg;
    byte_ovf_next  = byte_ovf_reg || (rx_byte_i && b[16]);
    pkt_ovf_next   = pkt_ovf_reg || (rx_pkt_i && p[16]);
    byte_snap_next = byte_snap_reg;
    err_snap_next  = err_snap_reg;
    if (lock) begin
      byte_snap_next = byte_live_reg;
      err_snap_next  = err_live_reg;
    end
    if (clear) begin
      byte_live_next = 16'h0000;
      err_live_next  = 8'h00;
      pkt_live_next  = 16'h0000;
      byte_ovf_next  = 1'b0;
      pkt_ovf_next   = 1'b0;
    end
  end

  // ----------------------------------------
  // control, interrupts, bus answer
  // ----------------------------------------
  assign events = {pkt_done,
                   pkt_ovf_next && !pkt_ovf_reg,
                   byte_ovf_next && !byte_ovf_reg};

  always_comb begin
    pkt_len_next = pkt_len_reg;
    ctrl_next    = ctrl_reg;
    irq_msk_next = irq_msk_reg;
    irq_sts_next = irq_sts_reg;
    ack_next     = req;
    rdata_next   = 32'h0000_0000;
    if (wr && lo_en) begin
      unique case (idx)
        `PKT_LEN_IDX: pkt_len_next = wdata;
        `CONTROL_IDX: ctrl_next = {14'h0000, wdata[1:0]};
        `IRQ_MASK_IDX: irq_msk_next = wdata[2:0];
        `IRQ_STATUS_IDX: irq_sts_next = irq_sts_reg & ~wdata[2:0];
        default: ;
      endcase
    end
    irq_sts_next = irq_sts_next | events;
    if (req && !wb_we_i) begin
      unique case (idx)
        `BYTE_TOTAL_IDX: rdata_next = {16'h0000, byte_snap_reg};
        `STATUS_CMD_IDX: rdata_next = {21'h000000, pkt_ovf_reg, byte_ovf_reg,
                                       1'b0, err_snap_reg};
        `PKT_LEN_IDX: rdata_next = {16'h0000, pkt_len_reg};
        `CONTROL_IDX: rdata_next = {16'h0000, ctrl_reg};
        `IRQ_STATUS_IDX: rdata_next = {29'h00000000, irq_sts_reg};
        `IRQ_MASK_IDX: rdata_next = {29'h00000000, irq_msk_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_live_reg <= 16'h0000;
      byte_snap_reg <= 16'h0000;
      err_live_reg  <= 8'h00;
      err_snap_reg  <= 8'h00;
      pkt_live_reg  <= 16'h0000;
      byte_ovf_reg  <= 1'b0;
      pkt_ovf_reg   <= 1'b0;
      pkt_len_reg   <= `PKT_LEN_RESET;
      ctrl_reg      <= `CONTROL_RESET;
      irq_sts_reg   <= 3'h0;
      irq_msk_reg   <= 3'h0;
      rdata_reg     <= 32'h0000_0000;
      ack_reg       <= 1'b0;
    end else begin
      byte_live_reg <= byte_live_next;
      byte_snap_reg <= byte_snap_next;
      err_live_reg  <= err_live_next;
      err_snap_reg  <= err_snap_next;
      pkt_live_reg  <= pkt_live_next;
      byte_ovf_reg  <= byte_ovf_next;
      pkt_ovf_reg   <= pkt_ovf_next;
      pkt_len_reg   <= pkt_len_next;
      ctrl_reg      <= ctrl_next;
      irq_sts_reg   <= irq_sts_next;
      irq_msk_reg   <= irq_msk_next;
      rdata_reg     <= rdata_next;
      ack_reg       <= ack_next;
    end
  end

  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;
  assign irq_o    = |(irq_sts_reg & irq_msk_reg);
endmodule : prbs_selftest_counters
`default_nettype wire

/* File: dv/prbs_selftest_counters_assertions.sv */
// checker of bus answer timing, status read-back and generator framing
// assumes it is bound to the self-test counters top module
`timescale 1ns/1ps
`default_nettype none
module prbs_selftest_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        byte_en_i,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_sfd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  status_reserved_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 10'h1c8 |-> wb_dat_o[15:11] == 5'h00 && !wb_dat_o[8])
    else $error("reserved status bits not zero");
  read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // ----------------------------------------
  // generator framing
  // ----------------------------------------
  sfd_value_a: assert property (tx_sfd_o |-> tx_valid_o && tx_data_o == 8'hd5)
    else $error("delimiter byte wrong");
  sfd_spacing_a: assert property (tx_sfd_o |=> !tx_sfd_o [*8])
    else $error("delimiters too close");
  tx_cause_a: assert property (tx_valid_o |-> $past(byte_en_i))
    else $error("byte without slot");
  read_c: cover property (wb_ack_o && !wb_we_i);
  write_c: cover property (wb_ack_o && wb_we_i);
  sfd_c: cover property (tx_sfd_o);
endmodule : prbs_selftest_checker

bind prbs_selftest_counters prbs_selftest_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .byte_en_i(byte_en_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_sfd_o(tx_sfd_o));
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench: registers, counters, locks, overflow irq, generator
// assumes a 200 MHz clock and a wishbone answer that the bench waits for
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [9:0] a_tot = 10'h1c4, a_st = 10'h1c8, a_len = 10'h1ec, a_ctl = 10'h058;
  localparam logic [9:0] a_ist = 10'h200, a_msk = 10'h204, a_bad = 10'h3fc;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        rx_byte = 1'b0, rx_err = 1'b0, rx_pkt = 1'b0, byte_en = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic        wb_ack_o, tx_valid_o, tx_sfd_o, irq_o;
  logic [7:0]  tx_data_o;
  logic [31:0] exp_q[$];
  int          num_errors = 0, n_checks = 0, tx_cnt = 0, n, i;

  prbs_selftest_counters dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_byte_i(rx_byte), .rx_err_i(rx_err), .rx_pkt_i(rx_pkt),
    .byte_en_i(byte_en), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_sfd_o(tx_sfd_o), .irq_o(irq_o));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rd(input logic [9:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic rx(input int cnt, input logic b, input logic er, input logic p);
    repeat (cnt) begin
      @(posedge clk_i);
      rx_byte <= b;
      rx_err  <= er;
      rx_pkt  <= p;
    end
    @(posedge clk_i);
    rx_byte <= 1'b0;
    rx_err  <= 1'b0;
    rx_pkt  <= 1'b0;
  endtask : rx
  // ----------------------------------------
  // result watchers
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      if (exp_q.size() > 0) check(wb_dat_o, exp_q.pop_front());
      else check(wb_dat_o, 32'hffff_ffff);
    end
    if (tx_valid_o === 1'b1) begin
      check(tx_sfd_o, tx_cnt % 11 == 7);
      if (tx_cnt % 11 < 8) check(tx_data_o, (tx_cnt % 11 == 7) ? 8'hd5 :
                                            (tx_cnt % 11 == 6) ? 8'h05 : 8'h55);
      tx_cnt++;
    end
  end

  initial begin
    #450000;
    num_errors++;
    print_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(33125));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(a_tot, 32'h0);
    rd(a_st, 32'h0);
    rd(a_len, 32'h05dc);
    rd(a_ctl, 32'h0);
    bus(1'b1, a_bad, 32'hffff);
    rd(a_bad, 32'h0);
    n = $urandom_range(40, 1);
    for (i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_byte <= 1'b1;
      rx_err  <= (i % 3 == 0);
    end
    rx(0, 1'b0, 1'b0, 1'b0);
    bus(1'b1, a_st, 32'h1);
    rd(a_tot, n);
    rd(a_st, (n + 2) / 3);
    rx(5, 1'b1, 1'b0, 1'b0);
    rd(a_tot, n);
    bus(1'b1, a_st, 32'h1);
    rd(a_tot, n + 5);
    bus(1'b1, a_st, 32'h2);
    rd(a_tot, n + 5);
    bus(1'b1, a_st, 32'h1);
    rd(a_tot, 32'h0);
    rx(65540, 1'b1, 1'b1, 1'b1);
    bus(1'b1, a_st, 32'h1);
    rd(a_tot, 32'hffff);
    rd(a_st, 32'h00ff);
    bus(1'b1, a_ctl, 32'h1);
    rx(1, 1'b1, 1'b0, 1'b1);
    bus(1'b1, a_st, 32'h1);
    rd(a_tot, 32'h0);
    rd(a_st, 32'h06ff);
    rd(a_ist, 32'h3);
    #1 check(irq_o, 1'b0);
    bus(1'b1, a_msk, 32'h3);
    #1 check(irq_o, 1'b1);
    bus(1'b1, a_ist, 32'h3);
    #1 check(irq_o, 1'b0);
    rd(a_st, 32'h06ff);
    bus(1'b1, a_st, 32'h2);
    bus(1'b1, a_st, 32'h1);
    rd(a_st, 32'h0);
    bus(1'b1, a_len, 32'h3);
    rd(a_len, 32'h3);
    sel <= 4'hc;
    bus(1'b1, a_len, 32'h7);
    sel <= 4'hf;
    rd(a_len, 32'h3);
    bus(1'b1, a_ctl, 32'h2);
    repeat (300) begin
      @(posedge clk_i);
      byte_en <= $urandom_range(1, 0);
    end
    @(posedge clk_i);
    byte_en <= 1'b0;
    rd(a_ist, 32'h4);
    @(posedge clk_i);
    check(tx_cnt >= 22, 1'b1);
    check(exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
